/* src/trx_top.v */
// Purpose: Two-direction registered bus transceiver with APB status
// Assumes: Pin inputs are asynchronous to pclk and are synchronised
// Notes:   Clocked capture is edge detected on the sampled direction clock
//
// Overview of operation
// RQ1: Eighteen data bits pass in each direction between card port and backplane port.
// RQ2: A high output enable puts that direction's outputs in high impedance whatever else happens.
// RQ3: A low output enable makes that direction drive the value chosen by latch, clock and inhibit.
// RQ4: With latch enable high the output follows the source data regardless of clock and inhibit.
// RQ5: With latch enable and inhibit low and a steady clock the output keeps its stored value.
// RQ6: With latch enable and inhibit low each rising clock edge captures and presents the source data.
// RQ7: With inhibit high and latch enable low clock edges are ignored and the stored value is kept.
// RQ8: Latching with the clock high keeps the level present before the latch enable fell.
// RQ9: The reverse direction behaves the same with its own four controls.
// RQ10: An undriven card-side input is held at its last valid level.
// RQ11: When powered down every output driver is disabled.
// RQ12: Card logic places no pull resistors on card-side inputs since hold logic keeps them valid.
// RQ13: The two directions store independently and the enable gates only the drivers.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "trx_regs.vh"

module trx_top #(
  parameter W         = `TRX_DATA_W,
  parameter LOG_DEPTH = `TRX_LOG_DEPTH,
  parameter LOG_AW    = `TRX_LOG_AW
) (
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`TRX_ADDR_W-1:0] paddr,
  input  wire [31:0]            pwdata,
  output wire [31:0]            prdata,
  output wire                   pready,
  output wire                   pslverr,
  input  wire [W-1:0]           a_in,
  input  wire                   a_in_driven,
  output wire [W-1:0]           a_out,
  output wire                   a_oe,
  input  wire [W-1:0]           b_in,
  output wire [W-1:0]           b_out,
  output wire                   b_oe,
  input  wire                   fwd_output_enable_n,
  input  wire                   fwd_latch_transparent,
  input  wire                   fwd_capture_clock,
  input  wire                   fwd_clock_inhibit,
  input  wire                   rev_output_enable_n,
  input  wire                   rev_latch_transparent,
  input  wire                   rev_capture_clock,
  input  wire                   rev_clock_inhibit,
  output wire                   log_ready
);

  localparam LW = W + 1;

  // ==========================================================
  // Input synchronisers
  reg  [7:0]     ctl_s1_r;
  reg  [7:0]     ctl_s2_r;
  reg  [7:0]     ctl_s3_r;
  reg  [2*W:0]   din_s1_r;
  reg  [2*W:0]   din_s2_r;
  reg  [W-1:0]   a_hold_r;

  wire [7:0] ctl_pins = {rev_output_enable_n, rev_latch_transparent, rev_capture_clock, rev_clock_inhibit,
                         fwd_output_enable_n, fwd_latch_transparent, fwd_capture_clock, fwd_clock_inhibit};

  wire [W-1:0] a_sync     = din_s2_r[W-1:0];
  wire [W-1:0] b_sync     = din_s2_r[2*W-1:W];
  wire         a_drv_sync = din_s2_r[2*W];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_s1_r <= 8'h99;
      ctl_s2_r <= 8'h99;
      ctl_s3_r <= 8'h99;
      din_s1_r <= {(2*W+1){1'b0}};
      din_s2_r <= {(2*W+1){1'b0}};
      a_hold_r <= {W{1'b0}};
    end else begin
      ctl_s1_r <= ctl_pins;
      ctl_s2_r <= ctl_s1_r;
      ctl_s3_r <= ctl_s2_r;
      din_s1_r <= {a_in_driven, b_in, a_in};
      din_s2_r <= din_s1_r;
      if (a_drv_sync) begin
        a_hold_r <= a_sync; // RQ10
      end
    end
  end

  // Card-side value with the keeper standing in for an undriven input
  wire [W-1:0] a_eff = a_drv_sync ? a_sync : a_hold_r; // RQ10

  // ==========================================================
  // Software control
  reg  [1:0] ctrl_r;
  wire       power_on = ctrl_r[`TRX_CTRL_POWER_BIT];
  wire       log_en   = ctrl_r[`TRX_CTRL_LOG_EN_BIT];

  // ==========================================================
  // Per-direction storage and drivers
  wire [2*W-1:0] src_w = {b_sync, a_eff};
  wire [2*W-1:0] out_w;
  wire [1:0]     oe_w;
  wire [1:0]     cap_w;

  genvar d;
  generate
    for (d = 0; d < 2; d = d + 1) begin : g_dir // RQ9
      reg  [W-1:0] store_r;
      reg  [W-1:0] store_nxt;
      reg          oe_r;
      wire         inh   = ctl_s2_r[d*4 + `TRX_CTL_INH_BIT];
      wire         clk_n = ctl_s2_r[d*4 + `TRX_CTL_CLK_BIT];
      wire         clk_p = ctl_s3_r[d*4 + `TRX_CTL_CLK_BIT];
      wire         le    = ctl_s2_r[d*4 + `TRX_CTL_LE_BIT];
      wire         oe_n  = ctl_s2_r[d*4 + `TRX_CTL_OEN_BIT];
      wire         rise  = clk_n & ~clk_p;
      wire         cap   = ~le & ~inh & rise; // RQ6 RQ7
      wire [W-1:0] src   = src_w[d*W +: W];

      always @* begin
        store_nxt = store_r; // RQ5 RQ7 RQ8
        if (le) begin
          store_nxt = src; // RQ4
        end else if (cap) begin
          store_nxt = src; // RQ6
        end
      end

      // Storage runs whatever the enable, so only the driver is gated
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          store_r <= {W{1'b0}};
          oe_r    <= 1'b0;
        end else begin
          store_r <= store_nxt; // RQ13
          oe_r    <= power_on & ~oe_n; // RQ2 RQ3 RQ11
        end
      end

      assign out_w[d*W +: W] = store_r;
      assign oe_w[d]         = oe_r;
      assign cap_w[d]        = cap;
    end
  endgenerate

  assign b_out = out_w[W-1:0]; // RQ1
  assign b_oe  = oe_w[0];
  assign a_out = out_w[2*W-1:W]; // RQ1
  assign a_oe  = oe_w[1];

  // ==========================================================
  // Capture log
  reg           ovr_r;
  reg           pop_ok_r;
  wire          fifo_in_ready;
  wire          fifo_out_valid;
  wire [LW-1:0] fifo_out_data;
  wire [LOG_AW:0] fifo_count;

  wire          push_req  = log_en & (cap_w[0] | cap_w[1]);
  wire          push_rev  = ~cap_w[0];
  wire [LW-1:0] push_data = push_rev ? {1'b1, src_w[2*W-1:W]} : {1'b0, src_w[W-1:0]};
  wire          push_lost = log_en & ((push_req & ~fifo_in_ready) | (cap_w[0] & cap_w[1]));

  // ==========================================================
  // APB slave
  reg  [31:0] prdata_r;
  reg         pready_r;
  reg         pslverr_r;
  reg  [31:0] rd_nxt;
  reg         err_nxt;

  wire setup_done = psel & penable & ~pready_r;
  wire xfer_done  = psel & penable & pready_r;
  wire wr_done    = xfer_done & pwrite;
  wire log_pop    = xfer_done & ~pwrite & (paddr == `TRX_LOG_DATA_OFS) & pop_ok_r;

  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr == `TRX_CTRL_OFS) begin
      rd_nxt[1:0] = ctrl_r;
    end else if (paddr == `TRX_STATUS_OFS) begin
      rd_nxt[7:0]                  = ctl_s2_r;
      rd_nxt[`TRX_STAT_FWD_OE_BIT] = oe_w[0];
      rd_nxt[`TRX_STAT_REV_OE_BIT] = oe_w[1];
    end else if (paddr == `TRX_FWD_DATA_OFS) begin
      rd_nxt[W-1:0] = out_w[W-1:0];
    end else if (paddr == `TRX_REV_DATA_OFS) begin
      rd_nxt[W-1:0] = out_w[2*W-1:W];
    end else if (paddr == `TRX_LOG_DATA_OFS) begin
      rd_nxt[`TRX_LOG_VALID_BIT] = fifo_out_valid;
      if (fifo_out_valid) begin
        rd_nxt[LW-1:0] = fifo_out_data;
      end
    end else if (paddr == `TRX_LOG_STAT_OFS) begin
      rd_nxt[LOG_AW:0]         = fifo_count;
      rd_nxt[`TRX_LOG_OVR_BIT] = ovr_r;
      rd_nxt[`TRX_LOG_RDY_BIT] = fifo_in_ready;
    end else begin
      err_nxt = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      pop_ok_r  <= 1'b0;
      ctrl_r    <= `TRX_CTRL_RESET;
      ovr_r     <= 1'b0;
    end else begin
      pready_r <= setup_done;
      if (setup_done) begin
        prdata_r  <= pwrite ? 32'h0000_0000 : rd_nxt;
        pslverr_r <= err_nxt;
        pop_ok_r  <= fifo_out_valid;
      end else begin
        pslverr_r <= 1'b0;
      end
      if (wr_done & (paddr == `TRX_CTRL_OFS)) begin
        ctrl_r <= pwdata[1:0];
      end
      // Overrun set wins over a same-cycle clear
      if (push_lost) begin
        ovr_r <= 1'b1;
      end else if (wr_done & (paddr == `TRX_LOG_STAT_OFS) & pwdata[`TRX_LOG_OVR_BIT]) begin
        ovr_r <= 1'b0;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  trx_fifo #(
    .W     (LW),
    .DEPTH (LOG_DEPTH),
    .AW    (LOG_AW)
  ) u_log (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (push_req),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data),
    .out_valid (fifo_out_valid),
    .out_ready (log_pop),
    .out_data  (fifo_out_data),
    .count     (fifo_count)
  );

  assign log_ready = fifo_in_ready;

endmodule // trx_top

`default_nettype wire

/* inc/trx_regs.vh */
// Purpose: Constants for the registered bus transceiver block
// Assumes: 32-bit APB, word aligned registers
// Notes:   Offsets are byte addresses
`ifndef TRX_REGS_VH
`define TRX_REGS_VH

// ==========================================================
// Widths and sizes
`define TRX_DATA_W        18
`define TRX_LOG_DEPTH     16
`define TRX_LOG_AW        4
`define TRX_ADDR_W        8

// ==========================================================
// Register offsets
`define TRX_CTRL_OFS      8'h00
`define TRX_STATUS_OFS    8'h04
`define TRX_FWD_DATA_OFS  8'h08
`define TRX_REV_DATA_OFS  8'h0c
`define TRX_LOG_DATA_OFS  8'h10
`define TRX_LOG_STAT_OFS  8'h14

// ==========================================================
// Field positions
`define TRX_CTRL_POWER_BIT    0
`define TRX_CTRL_LOG_EN_BIT   1
`define TRX_CTRL_RESET        2'h3
`define TRX_STAT_FWD_OE_BIT   8
`define TRX_STAT_REV_OE_BIT   9
`define TRX_LOG_VALID_BIT     31
`define TRX_LOG_OVR_BIT       8
`define TRX_LOG_RDY_BIT       9
`define TRX_CTL_INH_BIT       0
`define TRX_CTL_CLK_BIT       1
`define TRX_CTL_LE_BIT        2
`define TRX_CTL_OEN_BIT       3

`endif

/* src/trx_fifo.v */
// Purpose: Parameterised FIFO holding captured transfer words
// Assumes: DEPTH is a power of two equal to 2**AW
// Notes:   Flags are registered
`timescale 1ns/1ps
`default_nettype none

module trx_fifo #(
  parameter W     = 19,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire          clk,
  input  wire          rst_n,
  input  wire          in_valid,
  output wire          in_ready,
  input  wire [W-1:0]  in_data,
  output wire          out_valid,
  input  wire          out_ready,
  output wire [W-1:0]  out_data,
  output wire [AW:0]   count
);

  localparam [AW:0] FULL_CNT = DEPTH[AW:0];

  reg [W-1:0]  mem_r [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_r;
  reg [AW-1:0] rd_ptr_r;
  reg [AW:0]   count_r;
  reg [AW:0]   count_nxt;
  reg          in_ready_r;
  reg          out_valid_r;

  wire do_push = in_valid & in_ready_r;
  wire do_pop  = out_ready & out_valid_r;

  assign in_ready  = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data  = mem_r[rd_ptr_r];
  assign count     = count_r;

  // ==========================================================
  // Occupancy
  always @* begin
    count_nxt = count_r;
    if (do_push & ~do_pop) begin
      count_nxt = count_r + 1'b1;
    end else if (do_pop & ~do_push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_r    <= {AW{1'b0}};
      rd_ptr_r    <= {AW{1'b0}};
      count_r     <= {(AW+1){1'b0}};
      in_ready_r  <= 1'b1;
      out_valid_r <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r     <= count_nxt;
      in_ready_r  <= (count_nxt != FULL_CNT);
      out_valid_r <= (count_nxt != {(AW+1){1'b0}});
    end
  end

  // ==========================================================
  // Storage
  always @(posedge clk) begin
    if (do_push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

endmodule // trx_fifo

`default_nettype wire

/* testbench/trx_chk.sv */
// Purpose: Pin level assertions for the transceiver
// Assumes: Pins reach outputs three pclk edges later
// Notes:   Bound into trx_top
`timescale 1ns/1ps
`default_nettype none
module trx_chk #(parameter W = 18) (
  input wire logic         pclk, presetn, a_in_driven, a_oe, b_oe,
  input wire logic [W-1:0] a_in, b_in, a_out, b_out,
  input wire logic         fwd_output_enable_n, fwd_latch_transparent, fwd_capture_clock, fwd_clock_inhibit,
  input wire logic         rev_output_enable_n, rev_latch_transparent, rev_capture_clock, rev_clock_inhibit
);
  // ==========
  // Capture steps
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_fwd_cap;
    $past(fwd_capture_clock,3) && !$past(fwd_capture_clock,4) && !$past(fwd_latch_transparent,3)
      && !$past(fwd_clock_inhibit,3) && $past(presetn,4) && $past(a_in_driven,3);
  endsequence
  sequence s_rev_cap;
    $past(rev_capture_clock,3) && !$past(rev_capture_clock,4) && !$past(rev_latch_transparent,3)
      && !$past(rev_clock_inhibit,3) && $past(presetn,4);
  endsequence
  a_fwd_iso_off: assert property ($past(fwd_output_enable_n,3) |-> !b_oe) else $error("b_oe on");
  a_rev_iso_off: assert property ($past(rev_output_enable_n,3) |-> !a_oe) else $error("a_oe on");
  a_fwd_transp: assert property ($past(fwd_latch_transparent,3) && $past(a_in_driven,3) && $past(presetn,4)
    |-> b_out == $past(a_in,3)) else $error("b_out not transparent");
  a_rev_transp: assert property ($past(rev_latch_transparent,3) && $past(presetn,4)
    |-> a_out == $past(b_in,3)) else $error("a_out not transparent");
  a_fwd_capture: assert property (s_fwd_cap |-> b_out == $past(a_in,3)) else $error("b_out capture");
  a_rev_capture: assert property (s_rev_cap |-> a_out == $past(b_in,3)) else $error("a_out capture");
  a_fwd_hold: assert property (!$past(fwd_latch_transparent,3) && $past(presetn,4)
    && ($past(fwd_clock_inhibit,3) || $past(fwd_capture_clock,3) == $past(fwd_capture_clock,4))
    |-> $stable(b_out)) else $error("b_out moved");
  a_rev_hold: assert property (!$past(rev_latch_transparent,3) && $past(presetn,4)
    && ($past(rev_clock_inhibit,3) || $past(rev_capture_clock,3) == $past(rev_capture_clock,4))
    |-> $stable(a_out)) else $error("a_out moved");
endmodule // trx_chk
bind trx_top trx_chk #(.W(W)) i_trx_chk (.*);
`default_nettype wire

/* testbench/trx_card_model.sv */
// Purpose: Card logic and backplane driving the data inputs
// Assumes: Values change after a pclk edge
// Notes:   Released card lines toggle
`timescale 1ns/1ps
`default_nettype none
module trx_card_model (
  input wire logic   pclk, drive,
  input wire logic [17:0] card_val, bp_val,
  output var logic [17:0] a_in, b_in,
  output var logic   a_in_driven
);
  // ==========
  // Drivers, no pull resistors on card lines
  always @(posedge pclk) begin
    a_in_driven <= drive;
    a_in        <= drive ? card_val : ~a_in;
    b_in        <= bp_val;
  end
endmodule // trx_card_model
`default_nettype wire

/* testbench/tb_top.sv */
// Purpose: Self checking bench for the transceiver
// Assumes: Outputs settle six pclk edges after a change
// Notes:   Controls packed as oe_n, le, clk, inh
`timescale 1ns/1ps
`default_nettype none
`include "trx_regs.vh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, drive, pready, pslverr, err;
  logic        a_oe, b_oe, a_in_driven, log_ready;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [17:0] a_in, b_in, a_out, b_out, card_val, bp_val;
  logic [3:0]  fc, rc;
  int          miscompares, cmp_count;
  // ==========
  // Instances
  trx_top i_trx_top (.*, .fwd_output_enable_n(fc[3]), .fwd_latch_transparent(fc[2]), .fwd_capture_clock(fc[1]),
    .fwd_clock_inhibit(fc[0]), .rev_output_enable_n(rc[3]), .rev_latch_transparent(rc[2]),
    .rev_capture_clock(rc[1]), .rev_clock_inhibit(rc[0]));
  trx_card_model i_trx_card_model (.*);
  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end
  // ==========
  // Tasks
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task settle; repeat (6) @(posedge pclk); endtask
  task pulse(input logic rev);
    if (rev) rc[1] <= 1; else fc[1] <= 1;
    repeat (3) @(posedge pclk);
    if (rev) rc[1] <= 0; else fc[1] <= 0;
    repeat (3) @(posedge pclk);
  endtask
  task t_iso;
    fc <= 4'h8; rc <= 4'h8; settle;
    chk("b_oe", 0, b_oe);
    chk("a_oe", 0, a_oe);
    fc <= 4'h0; rc <= 4'h0; settle;
    chk("b_oe", 1, b_oe);
    chk("a_oe", 1, a_oe);
  endtask
  task t_transp;
    fc <= 4'h4; rc <= 4'h4; card_val <= 18'h2a5c3; bp_val <= 18'h15a3c; settle;
    chk("b_out", 18'h2a5c3, b_out);
    chk("a_out", 18'h15a3c, a_out);
    drive <= 0; settle;
    chk("b_out kept", 18'h2a5c3, b_out);
    drive <= 1; fc <= 4'h6; settle;
    fc <= 4'h2; card_val <= 18'h3ffff; settle;
    chk("b_out latched", 18'h2a5c3, b_out);
  endtask
  task t_capture;
    fc <= 4'h0; rc <= 4'h0; card_val <= 18'h1b2c4; settle; pulse(0); settle;
    chk("b_out clocked", 18'h1b2c4, b_out);
    chk("a_out apart", 18'h15a3c, a_out);
    card_val <= 18'h00f0f; settle;
    chk("b_out steady", 18'h1b2c4, b_out);
    fc <= 4'h1; settle; pulse(0); settle;
    chk("b_out inhibit", 18'h1b2c4, b_out);
    bp_val <= 18'h2f00e; fc <= 4'h0; settle; pulse(1); settle;
    chk("a_out clocked", 18'h2f00e, a_out);
  endtask
  task t_regs;
    apb(1, `TRX_CTRL_OFS, 32'h0); settle;
    chk("b_oe off", 0, b_oe);
    chk("a_oe off", 0, a_oe);
    apb(0, `TRX_STATUS_OFS, 0);
    chk("status oe", 0, rd[9:8]);
    apb(1, `TRX_CTRL_OFS, 32'h3);
    apb(0, 8'h3c, 0);
    chk("unmapped", 1, err);
    apb(0, `TRX_FWD_DATA_OFS, 0);
    chk("fwd data", 18'h1b2c4, rd);
  endtask
  task t_log;
    for (int i = 0; i < 16; i++) pulse(0);
    chk("log full", 0, log_ready);
    apb(0, `TRX_LOG_STAT_OFS, 0);
    chk("overrun", 1, rd[8]);
    apb(0, `TRX_LOG_DATA_OFS, 0);
    chk("log first", 32'h8001b2c4, rd);
    apb(0, `TRX_LOG_DATA_OFS, 0);
    chk("log rev", 32'h8006f00e, rd);
    for (int i = 0; i < 14; i++) apb(0, `TRX_LOG_DATA_OFS, 0);
    chk("log last", 32'h80000f0f, rd);
    apb(0, `TRX_LOG_STAT_OFS, 0);
    chk("log count", 0, rd[4:0]);
    apb(1, `TRX_LOG_STAT_OFS, 32'h100);
    apb(0, `TRX_LOG_STAT_OFS, 0);
    chk("overrun clr", 0, rd[8]);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========
  // Sequence and watchdog
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; drive = 1;
    card_val = 0; bp_val = 0; fc = 0; rc = 0; miscompares = 0; cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_iso; t_transp; t_capture; t_regs; t_log;
    wrap_up;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
